// file: rtl/serial_link_defs.svh
// Character codes, reset values and timing counts for the serial link
`ifndef SERIAL_LINK_DEFS_SVH
`define SERIAL_LINK_DEFS_SVH

// Comma characters, changeable here without touching the logic
`define K_IDLE 8'hBC
`define K_PKT_START 8'hDC
`define K_PKT_END 8'hFD
`define K_TX_BEGIN 8'h1C
`define K_RETX_REQ 8'h7C
`define K_FIXED_LAT 8'hFB
`define K_LINK_RESET 8'hFE
`define K_SPARE_0 8'h3C
`define K_SPARE_1 8'h5C
`define K_SPARE_2 8'h9C
`define K_SPARE_3 8'hFC
`define K_SPARE_4 8'hF7

// Data characters of the two idle variants, and the filler after reset
`define D_IDLE_A 8'hC5
`define D_IDLE_B 8'h50
`define D_NONE 8'h00

// Clock rate and printed times
`define CLK_MHZ 25
`define WORD_NS 5
`define RX_RESET_MS 4
`define LOCK_TYP_MS 1
`define STABLE_MS 500

// Derived cycle counts (ms times 1000 us times cycles per us)
`define RX_RESET_CYC (`RX_RESET_MS * 1000 * `CLK_MHZ)
`define STABLE_CYC (`STABLE_MS * 1000 * `CLK_MHZ)
`define RX_RST_PULSE_CYC 24'h000008
`define LINK_TO_CYC 5'h10

// Field widths
`define ALIGN_POS_W 5
`define TIMER_W 24

`endif

// file: rtl/serial_link_pkg.sv
// Types shared by the serial link start-up and control-word logic
package serial_link_pkg;

  // Start-up sequence states
  typedef enum logic [2:0] {
    ST_RX_RST = 3'h0,
    ST_WAIT_LOCK = 3'h1,
    ST_PEER = 3'h2,
    ST_STABLE = 3'h3,
    ST_ACTIVE = 3'h4
  } link_state_t;

  // Kinds of control word a user may send
  typedef enum logic [2:0] {
    CW_PKT_START = 3'h0,
    CW_PKT_END = 3'h1,
    CW_TX_BEGIN = 3'h2,
    CW_RETX_REQ = 3'h3,
    CW_FIXED_LAT = 3'h4,
    CW_LINK_RESET = 3'h5
  } ctl_kind_t;

  // One character on the line, comma flag plus code
  typedef struct packed {
    logic is_k;
    logic [7:0] chr;
  } char_t;

  // Control-word send request
  typedef struct packed {
    logic valid;
    ctl_kind_t kind;
    logic [7:0] data;
  } ctl_req_t;

  // Received control word
  typedef struct packed {
    logic valid;
    logic [7:0] kchr;
    logic [7:0] data;
  } rx_ctl_t;

endpackage : serial_link_pkg

// file: rtl/serial_link_startup.sv
// Serial link start-up handshake and control-word framing for one link end
`timescale 1ns/100ps
`include "serial_link_defs.svh"

module serial_link_startup #(
  parameter bit IS_MASTER = 1'b0,
  parameter bit TOWARD_FE = 1'b1,
  parameter bit HANDSHAKE_EN = 1'b1,
  parameter int unsigned RX_RESET_CYC = `RX_RESET_CYC,
  parameter int unsigned STABLE_CYC = `STABLE_CYC
) (
  // Reference clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Transceiver status, asynchronous
  input wire logic link_clk,
  input wire logic cdr_lock,
  input wire logic word_aligned,
  input wire logic [`ALIGN_POS_W-1:0] align_pos,
  // Character streams
  input wire serial_link_pkg::char_t rx_word,
  output serial_link_pkg::char_t tx_word,
  // User control words
  input wire serial_link_pkg::ctl_req_t ctl_req,
  output logic ctl_ready,
  output serial_link_pkg::rx_ctl_t rx_ctl,
  // Transceiver control and link status
  output logic tx_enable,
  output logic rx_reset,
  output logic logic_reset,
  output logic link_active
);

  typedef struct packed {
    serial_link_pkg::link_state_t fsm;
    logic [`TIMER_W-1:0] timer;
    logic [1:0] cdr_s;
    logic [1:0] aln_s;
    logic [`ALIGN_POS_W-1:0] pos_s0;
    logic [`ALIGN_POS_W-1:0] pos_s1;
    logic [1:0] lck_s;
    logic lck_prev;
    logic [4:0] clk_wd;
    logic tx_en;
    logic rx_rst;
    logic logic_rst;
    logic active;
    logic idle_b;
    logic ph;
    logic [7:0] pend;
    serial_link_pkg::char_t tx;
    logic ready;
    logic have_k;
    logic [7:0] rx_k;
    logic peer_b;
    serial_link_pkg::rx_ctl_t rx;
  } state_t;

  localparam state_t RESET_STATE = '{
    fsm: serial_link_pkg::ST_RX_RST,
    timer: `RX_RST_PULSE_CYC,
    tx_en: IS_MASTER,
    rx_rst: 1'b1,
    logic_rst: 1'b1,
    tx: '{is_k: 1'b0, chr: `D_NONE},
    default: '0
  };

  state_t s_reg;
  state_t s_next;
  logic clk_edge;
  logic clk_ok;
  logic rx_stable;
  logic align_ok;
  logic [7:0] req_k;

  // Spare commas carry no meaning
  function automatic logic is_spare(input logic [7:0] k);
    return k == `K_SPARE_0 || k == `K_SPARE_1 || k == `K_SPARE_2 ||
           k == `K_SPARE_3 || k == `K_SPARE_4;
  endfunction : is_spare

  // Next-state logic for the whole end
  always_comb begin
    s_next = s_reg;
    // Two-stage synchronisers for status pins and the link clock
    s_next.cdr_s = {s_reg.cdr_s[0], cdr_lock};
    s_next.aln_s = {s_reg.aln_s[0], word_aligned};
    s_next.pos_s0 = align_pos;
    s_next.pos_s1 = s_reg.pos_s0;
    s_next.lck_s = {s_reg.lck_s[0], link_clk};
    s_next.lck_prev = s_reg.lck_s[1];
    clk_edge = s_reg.lck_s[1] ^ s_reg.lck_prev;
    // Watchdog saturates so a stopped clock stays flagged
    if (clk_edge) begin
      s_next.clk_wd = '0;
    end else if (s_reg.clk_wd != 5'h1F) begin
      s_next.clk_wd = s_reg.clk_wd + 5'h01;
    end
    clk_ok = s_reg.clk_wd < `LINK_TO_CYC;
    rx_stable = s_reg.cdr_s[1] && clk_ok;
    // read-out side needs no bit position
    align_ok = s_reg.aln_s[1] &&
               (!TOWARD_FE || s_reg.pos_s1 == '0);
    s_next.logic_rst = !rx_stable;
    if (s_reg.timer != '0) begin
      s_next.timer = s_reg.timer - 24'h000001;
    end
    s_next.rx_rst = 1'b0;

    case (s_reg.fsm)
      serial_link_pkg::ST_RX_RST: begin
        s_next.rx_rst = 1'b1;
        if (s_reg.timer == '0) begin
          s_next.rx_rst = 1'b0;
          s_next.fsm = serial_link_pkg::ST_WAIT_LOCK;
          s_next.timer = RX_RESET_CYC[`TIMER_W-1:0];
        end
      end
      serial_link_pkg::ST_WAIT_LOCK: begin
        if (align_ok) begin
          s_next.fsm = serial_link_pkg::ST_PEER;
          if (!IS_MASTER) begin
            s_next.tx_en = 1'b1;
            s_next.idle_b = 1'b1;
          end
        end else if (s_reg.timer == '0) begin
          s_next.fsm = serial_link_pkg::ST_RX_RST;
          s_next.timer = `RX_RST_PULSE_CYC;
          s_next.rx_rst = 1'b1;
        end
      end
      serial_link_pkg::ST_PEER: begin
        if (!HANDSHAKE_EN || s_reg.peer_b) begin
          if (IS_MASTER) begin
            s_next.fsm = serial_link_pkg::ST_STABLE;
            s_next.timer = STABLE_CYC[`TIMER_W-1:0];
          end else begin
            s_next.fsm = serial_link_pkg::ST_ACTIVE;
          end
        end
      end
      serial_link_pkg::ST_STABLE: begin
        if (!align_ok) begin
          s_next.fsm = serial_link_pkg::ST_WAIT_LOCK;
          s_next.timer = RX_RESET_CYC[`TIMER_W-1:0];
        end else if (s_reg.timer == '0) begin
          s_next.fsm = serial_link_pkg::ST_ACTIVE;
          s_next.idle_b = 1'b1;
        end
      end
      serial_link_pkg::ST_ACTIVE: begin
        s_next.fsm = serial_link_pkg::ST_ACTIVE;
      end
      default: begin
        s_next.fsm = serial_link_pkg::ST_RX_RST;
      end
    endcase

    if (!rx_stable) begin
      s_next.fsm = serial_link_pkg::ST_RX_RST;
      s_next.timer = `RX_RST_PULSE_CYC;
      s_next.idle_b = 1'b0;
      s_next.tx_en = IS_MASTER;
    end
    s_next.active = s_next.fsm == serial_link_pkg::ST_ACTIVE;

    // Receive pairing; ignored while logic is in reset
    s_next.rx.valid = 1'b0;
    if (s_reg.logic_rst) begin
      s_next.have_k = 1'b0;
      s_next.peer_b = 1'b0;
    end else if (rx_word.is_k) begin
      s_next.rx_k = rx_word.chr;
      s_next.have_k = 1'b1;
    end else if (s_reg.have_k) begin
      s_next.have_k = 1'b0;
      if (s_reg.rx_k == `K_IDLE) begin
        if (rx_word.chr == `D_IDLE_B) begin
          s_next.peer_b = 1'b1;
        end else if (rx_word.chr == `D_IDLE_A) begin
          s_next.peer_b = 1'b0;
        end
      end else if (!is_spare(s_reg.rx_k)) begin
        s_next.rx.valid = 1'b1;
        s_next.rx.kchr = s_reg.rx_k;
        s_next.rx.data = rx_word.chr;
      end
    end

    case (ctl_req.kind)
      serial_link_pkg::CW_PKT_START: req_k = `K_PKT_START;
      serial_link_pkg::CW_PKT_END: req_k = `K_PKT_END;
      serial_link_pkg::CW_TX_BEGIN: req_k = `K_TX_BEGIN;
      serial_link_pkg::CW_RETX_REQ: req_k = `K_RETX_REQ;
      serial_link_pkg::CW_FIXED_LAT: req_k = `K_FIXED_LAT;
      default: req_k = `K_LINK_RESET;
    endcase

    // comma then data, alternating every cycle
    s_next.ph = ~s_reg.ph;
    if (!s_reg.ph) begin
      if (ctl_req.valid && s_reg.ready) begin
        s_next.tx = '{is_k: 1'b1, chr: req_k};
        s_next.pend = ctl_req.data;
      end else begin
        s_next.tx = '{is_k: 1'b1, chr: `K_IDLE};
        s_next.pend = s_reg.idle_b ? `D_IDLE_B : `D_IDLE_A;
      end
    end else begin
      s_next.tx = '{is_k: 1'b0, chr: s_reg.pend};
    end
    // Ready only in the cycle before a comma slot, so a taken word never
    // splits across slots
    s_next.ready = s_reg.ph && s_next.active;
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= RESET_STATE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign tx_word = s_reg.tx;
  assign ctl_ready = s_reg.ready;
  assign rx_ctl = s_reg.rx;
  assign tx_enable = s_reg.tx_en;
  assign rx_reset = s_reg.rx_rst;
  assign logic_reset = s_reg.logic_rst;
  assign link_active = s_reg.active;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Sequences for a taken fixed-latency message
  sequence fl_taken;
    ctl_req.valid && ctl_ready &&
    ctl_req.kind == serial_link_pkg::CW_FIXED_LAT;
  endsequence
  sequence fl_sent;
    tx_word.is_k && tx_word.chr == `K_FIXED_LAT ##1
    !tx_word.is_k && tx_word.chr == $past(ctl_req.data, 2);
  endsequence

  a_fixed_lat_insert: assert property (fl_taken |=> fl_sent)
    else $error("fixed-latency message not sent as comma plus payload");

  a_comma_data_pair: assert property (
    tx_word.is_k |=> !tx_word.is_k ##1 tx_word.is_k)
    else $error("comma and data characters do not alternate");

  // Idle data was chosen two edges back, when its comma was built
  a_idle_data_code: assert property (
    tx_word.is_k && tx_word.chr == `K_IDLE |=>
    tx_word.chr == ($past(s_reg.idle_b, 2) ? `D_IDLE_B : `D_IDLE_A))
    else $error("idle comma followed by wrong data character");

  a_reset_on_unstable: assert property (
    !s_reg.cdr_s[1] |=> logic_reset && !link_active)
    else $error("logic not held in reset while clock unstable");

  a_lock_loss_restart: assert property (
    link_active && !s_reg.cdr_s[1] |=>
    s_reg.fsm == serial_link_pkg::ST_RX_RST ##1 rx_reset)
    else $error("lock loss did not restart start-up");

  a_retry_after_wait: assert property (
    s_reg.fsm == serial_link_pkg::ST_WAIT_LOCK && s_reg.timer == '0 &&
    !align_ok && rx_stable |=> rx_reset)
    else $error("receiver not reset after lock interval");

  a_slave_ready_idle: assert property (
    !IS_MASTER && s_reg.fsm == serial_link_pkg::ST_PEER |->
    tx_enable && s_reg.idle_b)
    else $error("slave ready without transmitter or second idle");

  a_spare_ignored: assert property (
    !logic_reset && rx_word.is_k && is_spare(rx_word.chr) ##1
    !rx_word.is_k && !logic_reset |=> !rx_ctl.valid)
    else $error("spare comma reported as control word");

  a_bit0_lock: assert property (
    TOWARD_FE && s_reg.fsm == serial_link_pkg::ST_WAIT_LOCK && rx_stable &&
    s_reg.pos_s1 != '0 |=> s_reg.fsm != serial_link_pkg::ST_PEER)
    else $error("alignment accepted off bit zero");

  a_master_tx_on: assert property (IS_MASTER |-> tx_enable)
    else $error("master transmitter not enabled");

endmodule : serial_link_startup

// file: tb/peer_node.sv
// Behavioural master node at the far end of the slave's link
`timescale 1ns/100ps
module peer_node #(
  parameter int unsigned STABLE_CYC = 100
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Stream from the slave
  input wire serial_link_pkg::char_t tx_word,
  // Control word to inject at the next comma slot
  input wire logic inj_valid,
  input wire logic [7:0] inj_k,
  input wire logic [7:0] inj_d,
  // Stream toward the slave
  output serial_link_pkg::char_t rx_word
);
  logic data_slot = 1'b0;
  logic idle_b = 1'b0;
  logic seen_b = 1'b0;
  logic [7:0] held_d = 8'h00;
  int unsigned stab_cnt = 0;

  // Master transmits from time zero, never waiting on the slave
  // comma then data
  always @(posedge ref_clk) begin
    data_slot <= !data_slot;
    if (!data_slot) begin
      rx_word <= {1'b1, inj_valid ? inj_k : 8'hBC};
      held_d <= inj_valid ? inj_d : (idle_b ? 8'h50 : 8'hC5);
    end else begin
      rx_word <= {1'b0, held_d};
    end
  end

  // Idle change only after the slave idle stays settled for a while
  // stability delay
  always @(posedge ref_clk) begin
    if (rst) begin
      seen_b <= 1'b0;
      idle_b <= 1'b0;
      stab_cnt <= 0;
    end else begin
      if (tx_word === {1'b0, 8'h50}) seen_b <= 1'b1;
      if (tx_word === {1'b0, 8'hC5}) seen_b <= 1'b0;
      stab_cnt <= seen_b ? stab_cnt + 1 : 0;
      if (stab_cnt >= STABLE_CYC) idle_b <= 1'b1;
    end
  end
endmodule : peer_node

// file: tb/tb.sv
// Self-checking bench for the slave end of the link start-up
`timescale 1ns/100ps
module tb;
  typedef struct packed {
    serial_link_pkg::ctl_kind_t kind;
    logic [7:0] data;
    logic [7:0] kexp;
  } tx_row_t;

  logic ref_clk, rst, link_clk, lclk_run, cdr_lock, word_aligned;
  logic [4:0] align_pos;
  serial_link_pkg::char_t rx_word, tx_word;
  serial_link_pkg::ctl_req_t ctl_req;
  serial_link_pkg::rx_ctl_t rx_ctl;
  logic ctl_ready, tx_enable, rx_reset, logic_reset, link_active;
  logic inj_valid;
  logic [7:0] inj_k, inj_d;
  int n_errors, checks_done, i, w, nr;
  logic prev;
  // Kinds 6 and 7 fall back to link reset
  tx_row_t rows [8] = '{
    '{serial_link_pkg::CW_PKT_START, 8'h01, 8'hDC},
    '{serial_link_pkg::CW_PKT_END, 8'hA5, 8'hFD},
    '{serial_link_pkg::CW_TX_BEGIN, 8'h00, 8'h1C},
    '{serial_link_pkg::CW_RETX_REQ, 8'hFF, 8'h7C},
    '{serial_link_pkg::CW_FIXED_LAT, 8'hAA, 8'hFB},
    '{serial_link_pkg::CW_LINK_RESET, 8'h3E, 8'hFE},
    '{serial_link_pkg::ctl_kind_t'(3'h6), 8'h11, 8'hFE},
    '{serial_link_pkg::ctl_kind_t'(3'h7), 8'h22, 8'hFE}};
  // First six are acted on, the rest are spare and ignored
  logic [7:0] rx_k [11] = '{8'hDC, 8'hFD, 8'h1C, 8'h7C, 8'hFB, 8'hFE,
    8'h3C, 8'h5C, 8'h9C, 8'hFC, 8'hF7};

  serial_link_startup #(.IS_MASTER(1'b0), .TOWARD_FE(1'b1),
    .RX_RESET_CYC(200), .STABLE_CYC(100)) DUT (
    .ref_clk(ref_clk), .rst(rst), .link_clk(link_clk),
    .cdr_lock(cdr_lock), .word_aligned(word_aligned),
    .align_pos(align_pos), .rx_word(rx_word), .tx_word(tx_word),
    .ctl_req(ctl_req), .ctl_ready(ctl_ready), .rx_ctl(rx_ctl),
    .tx_enable(tx_enable), .rx_reset(rx_reset),
    .logic_reset(logic_reset), .link_active(link_active));

  peer_node #(.STABLE_CYC(100)) peer (.ref_clk(ref_clk), .rst(rst),
    .tx_word(tx_word), .inj_valid(inj_valid), .inj_k(inj_k),
    .inj_d(inj_d), .rx_word(rx_word));

  // Clocks; link clock offset so its edges never meet ref_clk edges
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever begin
      #160;
      if (lclk_run) link_clk = ~link_clk;
    end
  end

  task automatic ck(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
      n_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : ck

  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  // One control word, taken only on a ready cycle
  task automatic send(input tx_row_t r);
    int k;
    k = 0;
    while (ctl_ready !== 1'b1 && k < 8) begin
      @(negedge ref_clk);
      k++;
    end
    ck(ctl_ready === 1'b1, "never ready");
    ctl_req = '{1'b1, r.kind, r.data};
    @(negedge ref_clk);
    ctl_req.valid = 1'b0;
    ck(tx_word === {1'b1, r.kexp}, "wrong comma sent");
    ck(ctl_ready === 1'b0, "ready on data slot");
    @(negedge ref_clk);
    ck(tx_word === {1'b0, r.data}, "wrong data sent");
  endtask : send

  // Injected word must give exactly one pulse, or none when spare
  task automatic inject(input logic [7:0] kc, input bit exp);
    int seen;
    bit hit;
    seen = 0;
    hit = 0;
    inj_k = kc;
    inj_d = ~kc;
    inj_valid = 1'b1;
    repeat (2) @(negedge ref_clk);
    inj_valid = 1'b0;
    repeat (8) begin
      if (rx_ctl.valid === 1'b1) begin
        seen++;
        hit = (rx_ctl.kchr === kc) && (rx_ctl.data === ~kc);
      end
      @(negedge ref_clk);
    end
    ck(exp ? (seen == 1 && hit) : (seen == 0), "receive word wrong");
  endtask : inject

  // Watchdog, well past the expected run of about 700 cycles
  initial begin
    #200000;
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    rst = 1'b1;
    lclk_run = 1'b1;
    cdr_lock = 1'b1;
    word_aligned = 1'b1;
    align_pos = 5'h03;
    ctl_req = '0;
    inj_valid = 1'b0;
    inj_k = 8'h00;
    inj_d = 8'h00;
    n_errors = 0;
    checks_done = 0;
    repeat (8) @(negedge ref_clk);
    ck(rx_reset === 1'b1 && logic_reset === 1'b1, "reset outputs");
    ck(tx_enable === 1'b0 && link_active === 0, "slave idle");
    ck(ctl_ready === 1'b0 && rx_ctl.valid === 1'b0, "busy in reset");
    rst = 1'b0;
    // Boundary off bit zero: no lock, receiver reset retried
    nr = 0;
    prev = rx_reset;
    repeat (300) begin
      @(negedge ref_clk);
      if (rx_reset === 1'b1 && prev !== 1'b1) nr++;
      prev = rx_reset;
    end
    ck(nr >= 1, "no receiver reset retry");
    ck(tx_enable === 1'b0, "locked off bit zero");
    align_pos = 5'h00;
    w = 0;
    while (tx_enable !== 1'b1 && w < 300) begin
      @(negedge ref_clk);
      w++;
    end
    ck(tx_enable === 1'b1, "transmitter not enabled");
    repeat (4) @(negedge ref_clk);
    if (tx_word.is_k !== 1'b1) @(negedge ref_clk);
    ck(tx_word === {1'b1, 8'hBC}, "idle comma");
    @(negedge ref_clk);
    ck(tx_word === {1'b0, 8'h50}, "slave idle variant");
    w = 0;
    while (link_active !== 1'b1 && w < 400) begin
      @(negedge ref_clk);
      w++;
    end
    ck(link_active === 1'b1, "link not active");
    for (i = 0; i < 8; i++) begin
      send(rows[i]);
    end
    for (i = 0; i < 11; i++) begin
      inject(rx_k[i], i < 6);
    end
    // Lock drop while active; relock waits for alignment again
    cdr_lock = 1'b0;
    word_aligned = 1'b0;
    repeat (4) @(negedge ref_clk);
    ck(logic_reset === 1'b1 && link_active === 1'b0, "cdr loss");
    cdr_lock = 1'b1;
    repeat (60) @(negedge ref_clk);
    ck(tx_enable === 1'b0 && logic_reset === 1'b0, "unaligned lock");
    word_aligned = 1'b1;
    w = 0;
    while (link_active !== 1'b1 && w < 300) begin
      @(negedge ref_clk);
      w++;
    end
    ck(link_active === 1'b1, "no relock");
    // Link clock stops: logic back into reset, then restart
    lclk_run = 1'b0;
    repeat (30) @(negedge ref_clk);
    ck(logic_reset === 1'b1 && link_active === 0, "lock loss");
    lclk_run = 1'b1;
    w = 0;
    while (link_active !== 1'b1 && w < 1000) begin
      @(negedge ref_clk);
      w++;
    end
    ck(link_active === 1'b1, "no restart");
    end_sim();
  end
endmodule : tb
